// File: bench/ext_clock_source.sv
// outside logic-level clock source that feeds the clock input pin
`timescale 1ns/1ps
module ext_clock_source #(
  parameter int HALF_NS = 100
) (
  input  wire logic run,
  output logic      clk_out
);
  // ----------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------
  // the line stands low whenever the source is switched off
  initial clk_out = 1'b0;
  always begin
    if (run) begin
      #HALF_NS clk_out = ~clk_out;
    end else begin
      clk_out = 1'b0;
      @(run);
    end
  end
endmodule // ext_clock_source

// File: bench/tb_system_oscillator_select.sv
// self-checking bench of the system oscillator select block
`timescale 1ns/1ps
module tb_system_oscillator_select;
  logic                 CLK_SYS = 1'b0;
  logic                 RST_N = 1'b0;
  logic [1:0]           CFG_CLOCK_MODE = 2'h0;
  logic                 CFG_CLK_OUT_EN = 1'b1;
  logic [3:0]           ADDR = 4'h0;
  logic [7:0]           WDATA = 8'h00;
  logic                 WR = 1'b0;
  logic                 RD = 1'b0;
  logic                 SLEEP = 1'b0;
  logic                 LF_REQ = 1'b0;
  logic                 PRC_REQ = 1'b0;
  logic                 TIMER_BASE_ON = 1'b0;
  osc_pkg::periph_sel_s PSEL = '0;
  logic                 ext_run = 1'b0;
  logic                 CLK_IN_I, CLK_IN_IS_IO, CLK_OUT_O, CLK_OUT_OE, CLK_OUT_IS_IO, SYS_TICK;
  logic                 HF_READY, HF_STABLE, LF_READY;
  logic [7:0]           RDATA, d;
  osc_pkg::periph_tick_s PTICK;
  int                   bad_count = 0, cmp_count = 0, cyc = 0, n;
  logic [3:0]           codes [4] = '{4'hf, 4'hd, 4'hb, 4'h7};
  int                   rates [4] = '{320, 80, 20, 10};

  system_oscillator_select dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .CFG_CLOCK_MODE(CFG_CLOCK_MODE), .CFG_CLK_OUT_EN(CFG_CLK_OUT_EN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP), .LF_REQ(LF_REQ),
    .PRC_REQ(PRC_REQ), .TIMER_BASE_ON(TIMER_BASE_ON), .PSEL(PSEL), .TIMER0_TICK(1'b0),
    .TIMER1_TICK(1'b0), .TIMER2_TICK(1'b0), .CLK_IN_I(CLK_IN_I),
    .CLK_IN_IS_IO(CLK_IN_IS_IO), .CLK_OUT_O(CLK_OUT_O), .CLK_OUT_OE(CLK_OUT_OE),
    .CLK_OUT_IS_IO(CLK_OUT_IS_IO), .SYS_TICK(SYS_TICK), .PTICK(PTICK),
    .HF_READY(HF_READY), .HF_STABLE(HF_STABLE), .LF_READY(LF_READY));
  ext_clock_source ext_u (.run(ext_run), .clk_out(CLK_IN_I));

  // ----------------------------------------------------------------
  // clock, timeout and bus tasks
  // ----------------------------------------------------------------
  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // tick counts may slip by a few at the window ends
  task automatic near(string nm, int seen, int exp);
    if (seen >= exp - 3 && seen <= exp + 3) chk(nm, 16'(exp), 16'(exp));
    else chk(nm, 16'(seen), 16'(exp));
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // sel: 0 system tick, 1 converter tick, 2 power-up timer tick, 3 clock output rises
  task automatic cnt(int sel, int cycles, output int c);
    logic p;
    c = 0;
    p = CLK_OUT_O;
    repeat (cycles) begin
      @(posedge CLK_SYS);
      #1 if (sel == 3 ? CLK_OUT_O && !p : sel == 2 ? PTICK.pwrup : sel == 1 ? PTICK.adc
             : SYS_TICK) c++;
      p = CLK_OUT_O;
    end
  endtask
  task automatic do_reset(logic [1:0] mode);
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    CFG_CLOCK_MODE <= mode;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (400) @(posedge CLK_SYS);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(2'h0);
    #1 chk("clk_in_io", CLK_IN_IS_IO, 1'b1);
    chk("clk_out_oe", CLK_OUT_OE, 1'b1);
    rd(osc_pkg::CTRL_ADDR, d);
    chk("ctrl_reset", d, 8'h38);
    rd(osc_pkg::STAT_ADDR, d);
    chk("status_boot", d, 8'h11);
    rd(4'h5, d);
    chk("unmapped", d, 8'h00);
    wr(osc_pkg::STAT_ADDR, 8'hff);
    rd(osc_pkg::CTRL_ADDR, d);
    chk("ctrl_kept", d, 8'h38);
    for (int i = 0; i < 4; i++) begin
      wr(osc_pkg::CTRL_ADDR, {1'b0, codes[i], 3'h0});
      repeat (300) @(posedge CLK_SYS);
      cnt(1'b0, 1000, n);
      near("sys_rate", n, rates[i]);
      if (i == 0) begin
        cnt(3, 1000, n);
        near("clk_out_rate", n, 160);
      end
    end
    LF_REQ <= 1'b1;
    repeat (2000) @(posedge CLK_SYS);
    rd(osc_pkg::STAT_ADDR, d);
    chk("status_lf", d, 8'h13);
    chk("status_pins", {HF_READY, HF_STABLE, LF_READY}, 3'h7);
    PRC_REQ <= 1'b1;
    PSEL.adc <= 1'b1;
    SLEEP <= 1'b1;
    repeat (200) @(posedge CLK_SYS);
    cnt(1'b1, 1000, n);
    near("prc_rate", n, 12);
    cnt(1'b0, 200, n);
    chk("sleep_sys", 16'(n), 16'h0);
    SLEEP <= 1'b0;
    CFG_CLK_OUT_EN <= 1'b0;
    LF_REQ <= 1'b0;
    ext_run <= 1'b1;
    @(posedge CLK_SYS);
    #1 chk("clk_out_io", CLK_OUT_IS_IO, 1'b1);
    do_reset(2'h3);
    #1 chk("clk_in_ext", CLK_IN_IS_IO, 1'b0);
    rd(osc_pkg::STAT_ADDR, d);
    chk("status_ext", d, 8'h00);
    TIMER_BASE_ON <= 1'b1;
    cnt(1'b0, 1000, n);
    near("ext_rate", n, 100);
    wr(osc_pkg::CTRL_ADDR, 8'h7a);
    repeat (400) @(posedge CLK_SYS);
    cnt(1'b0, 1000, n);
    near("int_rate", n, 320);
    wr(osc_pkg::CTRL_ADDR, 8'h78);
    repeat (300) @(posedge CLK_SYS);
    cnt(1'b0, 1000, n);
    near("back_ext", n, 100);
    rd(osc_pkg::STAT_ADDR, d);
    chk("status_base", d, 8'h02);
    cnt(2, 1612, n);
    chk("pwrup_base", 16'(n), 16'h1);
    tally_and_finish();
  end
endmodule // tb_system_oscillator_select

// File: hw/osc_pkg.sv
// constants, types and field layout of the system oscillator select block
// Function
// - four clock modes from config bits: ext low, medium, high power, internal.
// - configured mode bits pick the oscillator after power-up and every reset.
// - external modes run from the clock input pin; second pin freed.
// - internal mode releases the clock input pin for general I/O.
// - a config bit makes the clock output pin a clock or general I/O.
// - 16 MHz oscillator feeds postscaler; both oscillators enter one frequency mux.
// - high-frequency oscillator on for HF codes with mode 00 or source 1x.
// - start-up oscillator drives internal clock until high-frequency oscillator stabilises.
// - high-frequency ready flag follows the running high-frequency oscillator; the code holds it while a clock switch is in flight.
// - high-frequency stable flag set only within 0.5% of final frequency.
// - low-frequency oscillator on for code 000x as system clock or peripheral need.
// - low-frequency oscillator clocks power-up timer and watchdog regardless of selection.
// - low-frequency ready flag follows the running low-frequency oscillator; the code holds it while a clock switch is in flight.
// - peripheral oscillator starts whenever a peripheral requests it, no software enable.
// - peripheral oscillator keeps running during sleep.
// - fixed per-peripheral clock routing; logic cell may use all seven sources.
// - any reset loads frequency select with 0111, 500 kHz.
// - duplicate codes allowed; same-oscillator change is faster than oscillator change.
// - source select can switch to the external clock named by mode bits.
// - source select can switch to the internal block in any mode.
// - mode bits 11 high, 10 medium, 01 low power external, 00 internal.
// - frequency codes 1111 down to 000x map to fixed divided frequencies.
// - source select 1x internal, 01 reserved, 00 configured mode.
// - switch waits start-up, old falling edge, holds low, new rising edge.
package osc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h1;
  localparam int         FREQ_LSB  = 3;
  localparam int         SRC_LSB   = 0;
  localparam int         STAT_HFR  = 4;
  localparam int         STAT_LFR  = 1;
  localparam int         STAT_HFS  = 0;
  localparam logic [3:0] FREQ_RST  = 4'h7;
  localparam logic [1:0] SRC_RST   = 2'h0;
  localparam logic [1:0] MODE_INT  = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int HF_HZ         = 16_000_000;
  localparam int LF_HZ         = 31_000;
  localparam int PRC_HZ        = 600_000;
  localparam int HF_START_NS   = 2000;
  localparam int HF_SETTLE_NS  = 2000;
  localparam int HF_START_CYC  = (HF_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HF_SETTLE_CYC = (HF_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LF_DIV        = CLK_HZ / LF_HZ;
  localparam int PRC_DIV       = CLK_HZ / PRC_HZ;
  localparam logic [15:0] HF_INC =
    16'(64'd16_000_000 * 64'd65536 / 64'd50_000_000);
  localparam logic [1:0] EXT_START_TICKS = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_EXT = 2'h0, SRC_HF = 2'h1, SRC_LF = 2'h2} src_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_FALL  = 5'h04,
    ST_HOLD  = 5'h08,
    ST_DONE  = 5'h10
  } state_e;

  typedef struct packed {
    logic       adc;
    logic       wgen;
    logic       acc_osc;
    logic       pwm;
    logic       timer1;
    logic [2:0] lcell;
  } periph_sel_s;

  typedef struct packed {
    logic adc;
    logic wgen;
    logic acc_osc;
    logic pwm;
    logic timer1;
    logic lcell;
    logic pwrup;
    logic wdog;
  } periph_tick_s;

endpackage

// File: hw/system_oscillator_select.sv
// system clock source selection, oscillator models and clock routing
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module system_oscillator_select (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire logic [1:0]           CFG_CLOCK_MODE,
  input  wire logic                 CFG_CLK_OUT_EN,
  input  wire logic [3:0]           ADDR,
  input  wire logic [7:0]           WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic      [7:0]           RDATA,
  input  wire logic                 SLEEP,
  input  wire logic                 LF_REQ,
  input  wire logic                 PRC_REQ,
  input  wire logic                 TIMER_BASE_ON,
  input  wire osc_pkg::periph_sel_s PSEL,
  input  wire logic                 TIMER0_TICK,
  input  wire logic                 TIMER1_TICK,
  input  wire logic                 TIMER2_TICK,
  input  wire logic                 CLK_IN_I,
  output logic                      CLK_IN_IS_IO,
  output logic                      CLK_OUT_O,
  output logic                      CLK_OUT_OE,
  output logic                      CLK_OUT_IS_IO,
  output logic                      SYS_TICK,
  output osc_pkg::periph_tick_s     PTICK,
  output logic                      HF_READY,
  output logic                      HF_STABLE,
  output logic                      LF_READY
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0]      freq_reg;
  logic [1:0]      src_sel_reg;
  logic [7:0]      rdata_reg;
  logic [2:0]      stat_reg;
  logic            int_sel;
  logic            hf_en;
  logic            lf_en;
  logic            hf_on;
  logic            lf_on;
  logic [7:0]      hf_cnt_reg;
  logic            hf_ready_reg;
  logic            hf_stable_reg;
  logic [15:0]     hf_acc_reg;
  logic            hf_tick_reg;
  logic [8:0]      post_cnt_reg;
  logic [10:0]     lf_cnt_reg;
  logic            lf_tick_reg;
  logic            lf_ready_reg;
  logic [6:0]      prc_cnt_reg;
  logic            prc_tick_reg;
  logic            pin_s1_reg;
  logic            pin_s2_reg;
  logic            pin_s3_reg;
  logic            ext_lvl_reg;
  logic            ext_rise_reg;
  osc_pkg::src_e   want_src;
  logic [3:0]      want_shift;
  osc_pkg::src_e   cur_src_reg;
  logic [3:0]      cur_shift_reg;
  osc_pkg::state_e state_reg;
  logic [1:0]      ext_cnt_reg;
  logic            boot_reg;
  logic            changed;
  logic            want_ready;
  logic            cur_tick;
  logic            want_tick;
  logic            sys_tick_reg;
  logic            clk_out_reg;
  osc_pkg::periph_tick_s ptick_reg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      freq_reg <= osc_pkg::FREQ_RST;
      src_sel_reg <= osc_pkg::SRC_RST;
    end else if (WR && ADDR == osc_pkg::CTRL_ADDR) begin
      freq_reg <= WDATA[osc_pkg::FREQ_LSB +: 4];
      src_sel_reg <= WDATA[osc_pkg::SRC_LSB +: 2];
    end
  end

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (RD && ADDR == osc_pkg::CTRL_ADDR) begin
      rdata_reg <= {1'b0, freq_reg, 1'b0, src_sel_reg};
    end else if (RD && ADDR == osc_pkg::STAT_ADDR) begin
      rdata_reg <= {3'h0, stat_reg[2], 2'h0, stat_reg[1:0]};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // selection decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] shift_of(input logic [3:0] f);
    logic [3:0] s;
    s = 4'h9;
    case (f)
      4'hf: s = 4'h0;
      4'he: s = 4'h1;
      4'hd: s = 4'h2;
      4'hc: s = 4'h3;
      4'hb: s = 4'h4;
      4'ha: s = 4'h5;
      4'h9: s = 4'h6;
      4'h8: s = 4'h7;
      4'h7: s = 4'h5;
      4'h6: s = 4'h6;
      4'h5: s = 4'h7;
      4'h4: s = 4'h8;
      default: s = 4'h9;
    endcase
    return s;
  endfunction

  // reserved source code 01 behaves as 00
  assign int_sel = src_sel_reg[1] || CFG_CLOCK_MODE == osc_pkg::MODE_INT;
  assign hf_en   = int_sel && freq_reg[3:1] != 3'h0;
  assign lf_en   = (int_sel && freq_reg[3:1] == 3'h0) || LF_REQ || TIMER_BASE_ON;

  always_comb begin
    if (!int_sel) begin
      want_src   = osc_pkg::SRC_EXT;
      want_shift = 4'h0;
    end else if (freq_reg[3:1] == 3'h0) begin
      want_src   = osc_pkg::SRC_LF;
      want_shift = 4'h0;
    end else begin
      want_src   = osc_pkg::SRC_HF;
      want_shift = shift_of(freq_reg);
    end
  end

  // the source still in use stays powered until the switch completes
  assign hf_on = hf_en || cur_src_reg == osc_pkg::SRC_HF;
  assign lf_on = lf_en || cur_src_reg == osc_pkg::SRC_LF;

  // ----------------------------------------------------------------
  // high-frequency oscillator and postscaler
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      hf_cnt_reg    <= 8'h00;
      hf_ready_reg  <= 1'b0;
      hf_stable_reg <= 1'b0;
    end else if (!hf_on) begin
      hf_cnt_reg    <= 8'h00;
      hf_ready_reg  <= 1'b0;
      hf_stable_reg <= 1'b0;
    end else begin
      if (hf_cnt_reg != 8'(osc_pkg::HF_START_CYC + osc_pkg::HF_SETTLE_CYC)) begin
        hf_cnt_reg <= hf_cnt_reg + 8'h01;
      end
      hf_ready_reg  <= hf_cnt_reg >= 8'(osc_pkg::HF_START_CYC);
      hf_stable_reg <= hf_cnt_reg ==
                       8'(osc_pkg::HF_START_CYC + osc_pkg::HF_SETTLE_CYC);
    end
  end

  // phase accumulator stands in for the start-up and main oscillator
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      hf_acc_reg  <= 16'h0000;
      hf_tick_reg <= 1'b0;
    end else if (hf_on) begin
      {hf_tick_reg, hf_acc_reg} <= {1'b0, hf_acc_reg} + {1'b0, osc_pkg::HF_INC};
    end else begin
      hf_acc_reg  <= 16'h0000;
      hf_tick_reg <= 1'b0;
    end
  end

  // one shared counter keeps every divided output glitch-free
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_reg <= 9'h000;
    end else if (hf_tick_reg) begin
      post_cnt_reg <= post_cnt_reg + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // low-frequency and peripheral oscillators
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      lf_cnt_reg   <= 11'h000;
      lf_tick_reg  <= 1'b0;
      lf_ready_reg <= 1'b0;
    end else if (!lf_on) begin
      lf_cnt_reg   <= 11'h000;
      lf_tick_reg  <= 1'b0;
      lf_ready_reg <= 1'b0;
    end else begin
      lf_tick_reg <= lf_cnt_reg == 11'(osc_pkg::LF_DIV - 1);
      lf_cnt_reg  <= (lf_cnt_reg == 11'(osc_pkg::LF_DIV - 1)) ? 11'h000
                                                            : lf_cnt_reg + 11'h001;
      if (lf_tick_reg) begin
        lf_ready_reg <= 1'b1;
      end
    end
  end

  // runs on request alone, sleep does not stop it
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      prc_cnt_reg  <= 7'h00;
      prc_tick_reg <= 1'b0;
    end else if (PRC_REQ) begin
      prc_tick_reg <= prc_cnt_reg == 7'(osc_pkg::PRC_DIV - 1);
      prc_cnt_reg  <= (prc_cnt_reg == 7'(osc_pkg::PRC_DIV - 1)) ? 7'h00
                                                             : prc_cnt_reg + 7'h01;
    end else begin
      prc_cnt_reg  <= 7'h00;
      prc_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // external clock input
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_s3_reg   <= 1'b0;
      ext_lvl_reg  <= 1'b0;
      ext_rise_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= CLK_IN_I;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      ext_rise_reg <= 1'b0;
      if (pin_s2_reg == pin_s3_reg) begin
        ext_lvl_reg  <= pin_s3_reg;
        ext_rise_reg <= pin_s3_reg && !ext_lvl_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock switch sequencer
  // ----------------------------------------------------------------
  function automatic logic src_tick(input osc_pkg::src_e s, input logic [3:0] sh);
    logic       t;
    logic [8:0] m;
    t = 1'b0;
    m = 9'((10'h001 << sh) - 10'h001);
    case (s)
      osc_pkg::SRC_EXT: t = ext_rise_reg;
      osc_pkg::SRC_HF:  t = hf_tick_reg && ((post_cnt_reg & m) == m);
      osc_pkg::SRC_LF:  t = lf_tick_reg;
      default:          t = 1'b0;
    endcase
    return t;
  endfunction

  // a process, so the tick sources read inside the function wake it up
  always_comb begin
    cur_tick  = src_tick(cur_src_reg, cur_shift_reg);
    want_tick = src_tick(want_src, want_shift);
  end
  assign changed   = want_src != cur_src_reg || want_shift != cur_shift_reg;

  always_comb begin
    case (want_src)
      osc_pkg::SRC_HF: want_ready = hf_ready_reg;
      osc_pkg::SRC_LF: want_ready = lf_ready_reg;
      default:         want_ready = ext_cnt_reg == osc_pkg::EXT_START_TICKS;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= osc_pkg::ST_IDLE;
      cur_src_reg   <= osc_pkg::SRC_HF;
      cur_shift_reg <= 4'h0;
      ext_cnt_reg   <= 2'h0;
      boot_reg      <= 1'b1;
    end else if (boot_reg) begin
      boot_reg      <= 1'b0;
      cur_src_reg   <= want_src;
      cur_shift_reg <= want_shift;
    end else begin
      case (state_reg)
        osc_pkg::ST_IDLE: begin
          ext_cnt_reg <= 2'h0;
          if (changed) begin
            state_reg <= (want_src == cur_src_reg) ? osc_pkg::ST_FALL
                                                   : osc_pkg::ST_START;
          end
        end
        osc_pkg::ST_START: begin
          if (ext_rise_reg && ext_cnt_reg != osc_pkg::EXT_START_TICKS) begin
            ext_cnt_reg <= ext_cnt_reg + 2'h1;
          end
          if (want_ready) begin
            state_reg <= osc_pkg::ST_FALL;
          end
        end
        osc_pkg::ST_FALL: begin
          if (cur_tick) begin
            state_reg <= osc_pkg::ST_HOLD;
          end
        end
        osc_pkg::ST_HOLD: begin
          if (want_tick) begin
            cur_src_reg   <= want_src;
            cur_shift_reg <= want_shift;
            state_reg     <= osc_pkg::ST_DONE;
          end
        end
        osc_pkg::ST_DONE: begin
          state_reg <= osc_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= osc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // status view is frozen while a switch is in flight
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= 3'h0;
    end else if (state_reg == osc_pkg::ST_IDLE || state_reg == osc_pkg::ST_DONE) begin
      stat_reg <= {hf_ready_reg, lf_ready_reg, hf_stable_reg};
    end
  end

  assign HF_READY  = stat_reg[2];
  assign LF_READY  = stat_reg[1];
  assign HF_STABLE = stat_reg[0];

  // ----------------------------------------------------------------
  // system clock, pins and peripheral routing
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sys_tick_reg <= 1'b0;
      clk_out_reg  <= 1'b0;
    end else begin
      sys_tick_reg <= cur_tick && !boot_reg && state_reg != osc_pkg::ST_HOLD
                      && !SLEEP;
      if (sys_tick_reg && CFG_CLK_OUT_EN) begin
        clk_out_reg <= !clk_out_reg;
      end
    end
  end

  assign SYS_TICK     = sys_tick_reg;
  assign CLK_OUT_O     = clk_out_reg;
  assign CLK_OUT_OE    = CFG_CLK_OUT_EN;
  assign CLK_OUT_IS_IO = !CFG_CLK_OUT_EN;
  assign CLK_IN_IS_IO  = CFG_CLOCK_MODE == osc_pkg::MODE_INT;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ptick_reg <= '0;
    end else begin
      ptick_reg.adc     <= PSEL.adc ? prc_tick_reg : sys_tick_reg;
      ptick_reg.wgen    <= PSEL.wgen ? hf_tick_reg : sys_tick_reg;
      ptick_reg.acc_osc <= PSEL.acc_osc ? hf_tick_reg : sys_tick_reg;
      ptick_reg.pwm     <= PSEL.pwm ? TIMER2_TICK : sys_tick_reg;
      ptick_reg.timer1  <= PSEL.timer1 ? lf_tick_reg : sys_tick_reg;
      ptick_reg.pwrup   <= lf_tick_reg;
      ptick_reg.wdog    <= lf_tick_reg;
      case (PSEL.lcell)
        3'h0:    ptick_reg.lcell <= sys_tick_reg;
        3'h1:    ptick_reg.lcell <= prc_tick_reg;
        3'h2:    ptick_reg.lcell <= hf_tick_reg;
        3'h3:    ptick_reg.lcell <= lf_tick_reg;
        3'h4:    ptick_reg.lcell <= TIMER0_TICK;
        3'h5:    ptick_reg.lcell <= TIMER1_TICK;
        3'h6:    ptick_reg.lcell <= TIMER2_TICK;
        default: ptick_reg.lcell <= 1'b0;
      endcase
    end
  end

  assign PTICK = ptick_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  sequence seq_sw_begin;
    state_reg == osc_pkg::ST_IDLE && !boot_reg && changed;
  endsequence

  sequence seq_same_osc;
    seq_sw_begin ##0 want_src == cur_src_reg;
  endsequence

  AST_SAME_OSC_FAST: assert property (seq_same_osc |=> state_reg == osc_pkg::ST_FALL)
    else $error("same-oscillator change did not skip start-up");
  AST_OTHER_OSC_START: assert property (seq_sw_begin ##0 want_src != cur_src_reg
      |=> state_reg == osc_pkg::ST_START)
    else $error("oscillator change skipped start-up wait");
  AST_HOLD_LOW: assert property (state_reg == osc_pkg::ST_HOLD |=> !sys_tick_reg)
    else $error("system clock ticked while held low");
  AST_HF_STARTUP: assert property ($rose(hf_on) |-> !hf_ready_reg [*8])
    else $error("high-frequency ready set before start-up delay");
  AST_HF_OFF: assert property (!hf_on |=> !hf_ready_reg && !hf_stable_reg)
    else $error("high-frequency flags set while oscillator off");
  AST_HF_STABLE: assert property (hf_stable_reg |-> hf_ready_reg)
    else $error("stable flag without ready flag");
  AST_LF_OFF: assert property (!lf_on |=> !lf_ready_reg && !lf_tick_reg)
    else $error("low-frequency ready while oscillator off");
  AST_PRC_RUNS: assert property (PRC_REQ [*8] ##0 SLEEP |-> ##[0:90] prc_tick_reg
      || !PRC_REQ)
    else $error("peripheral oscillator did not run on request");
  AST_RESET_FREQ: assert property ($rose(rst_n) |-> freq_reg == osc_pkg::FREQ_RST)
    else $error("frequency select not loaded with reset value");
  AST_DONE_CUR: assert property (state_reg == osc_pkg::ST_DONE |->
      $past(want_tick) && cur_src_reg == $past(want_src))
    else $error("switch completed without a new-clock edge");
  AST_TIMER_BASE: assert property (lf_tick_reg |=> ptick_reg.pwrup && ptick_reg.wdog)
    else $error("timer base not taken from low-frequency oscillator");

endmodule // system_oscillator_select
